// ===== include/mbal_pkg.sv
// Package for the memory balloon device: register map, feature bits, queue indices, status bits.
// Assumes a 32-bit AXI4-Lite register bus and a single clock domain.
package mbal_pkg;
    // ********************************
    // Register byte offsets
    // ********************************
    localparam logic [7:0] OFF_DEV_FEATURES = 8'h00;
    localparam logic [7:0] OFF_DRV_FEATURES = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_TARGET = 8'h0c;
    localparam logic [7:0] OFF_CURRENT = 8'h10;
    localparam logic [7:0] OFF_HOST_TARGET = 8'h14;
    localparam logic [7:0] OFF_EVENTS = 8'h18;
    localparam logic [7:0] OFF_QUEUE_SEL = 8'h1c;
    localparam logic [7:0] OFF_QUEUE_AVAIL = 8'h20;
    localparam logic [7:0] OFF_QUEUE_NOTIFY = 8'h24;
    localparam logic [7:0] OFF_ACCEPTED = 8'h28;
    localparam logic [7:0] OFF_LEGACY = 8'h2c;
    localparam logic [7:0] OFF_ID = 8'h30;
    // ********************************
    // Feature bits and fields
    // ********************************
    localparam int FEAT_TELL_BEFORE_REUSE = 0;
    localparam int FEAT_STATS_QUEUE_PRESENT = 1;
    localparam int FEAT_DEFLATE_ON_LOW_MEMORY = 2;
    localparam logic [2:0] FEAT_RESET = 3'h7;
    localparam int STATUS_FEATURES_OK = 3;
    localparam int STATUS_DRIVER_OK = 2;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [1:0] QUEUE_GIVE = 2'h0;
    localparam logic [1:0] QUEUE_RETURN = 2'h1;
    localparam logic [1:0] QUEUE_STATS = 2'h2;
    localparam int PAGE_SHIFT = 12;
    localparam int EVT_CONFIG_CHANGE = 0;
    localparam int EVT_STATS_READY = 1;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Arbitrary neutral identity value.
    localparam logic [31:0] DEVICE_ID_DEFAULT = 32'h0000_00a1;
endpackage

// ===== hdl/mbal_device.sv
// Memory balloon device core: configuration space, feature negotiation and request acknowledgement.
// Assumes an AXI4-Lite master on the same clock and that descriptors arrive on a simple handshake.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Give queue 0, return queue 1; stats queue 2 only if its feature is offered.
// - Feature bits: tell-before-reuse 0, stats queue 1, deflate on low memory 2.
// - Features-ok write is refused if offered tell-before-reuse was not accepted.
// - Legacy mode works without tell-before-reuse, allowing reuse before acknowledgement.
// - Configuration holds target count then current count, each 32-bit little-endian.
// - Both fields are little-endian even in legacy mode.
// - Target above current wants more pages, below wants fewer.
// - Page entries are 32-bit addresses divided by 4096.
// - Every give and return request is acknowledged by using its descriptor.
// - With tell-before-reuse accepted, device may alter given pages until acknowledgement of give or return.
// - Legacy device applies current count only once its top byte is written.
module mbal_device #(
    parameter logic [31:0] DEVICE_ID = mbal_pkg::DEVICE_ID_DEFAULT
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Request descriptors from the queue engine
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [1:0] req_queue,
    input wire logic [15:0] req_desc_id,
    // Used-descriptor acknowledgement
    output logic used_valid,
    output logic [1:0] used_queue,
    output logic [15:0] used_desc_id,
    // Notifications and state to the transport
    output logic config_change,
    output logic stats_request,
    output logic balloon_wants_more,
    output logic balloon_wants_fewer,
    output logic page_alter_allowed
);
    // ********************************
    // State
    // ********************************
    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [2:0] dev_feat;
        logic [2:0] drv_feat;
        logic [7:0] status;
        logic [31:0] target;
        logic [31:0] current;
        logic [31:0] current_stage;
        logic legacy;
        logic [1:0] events;
        logic [1:0] queue_sel;
        logic used_valid;
        logic [1:0] used_queue;
        logic [15:0] used_desc;
        logic [31:0] accepted;
        logic cfg_pulse;
        logic stats_pulse;
    } mbal_state_t;

    mbal_state_t s_q;
    mbal_state_t s_d;

    // Merges byte lanes of a write into an old value.
    function automatic logic [31:0] mbal_merge(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = data[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Tells whether a queue index exists under the current offer.
    function automatic logic mbal_queue_ok(input logic [1:0] q, input logic [2:0] feat);
        return (q == mbal_pkg::QUEUE_GIVE) || (q == mbal_pkg::QUEUE_RETURN) ||
               ((q == mbal_pkg::QUEUE_STATS) && feat[mbal_pkg::FEAT_STATS_QUEUE_PRESENT]);
    endfunction

    // Gives the state after reset; every field is named so that a new one cannot be left out.
    function automatic mbal_state_t mbal_reset_state();
        mbal_state_t r;
        r.aw_held = 1'h0;
        r.aw_addr = 8'h00;
        r.w_held = 1'h0;
        r.w_data = 32'h0000_0000;
        r.w_strb = 4'h0;
        r.bvalid = 1'h0;
        r.bresp = mbal_pkg::RESP_OKAY;
        r.rvalid = 1'h0;
        r.rdata = 32'h0000_0000;
        r.rresp = mbal_pkg::RESP_OKAY;
        r.dev_feat = mbal_pkg::FEAT_RESET;
        r.drv_feat = 3'h0;
        r.status = mbal_pkg::STATUS_RESET;
        r.target = mbal_pkg::COUNT_RESET;
        r.current = mbal_pkg::COUNT_RESET;
        r.current_stage = mbal_pkg::COUNT_RESET;
        r.legacy = 1'h0;
        r.events = 2'h0;
        r.queue_sel = 2'h0;
        r.used_valid = 1'h0;
        r.used_queue = 2'h0;
        r.used_desc = 16'h0000;
        r.accepted = 32'h0000_0000;
        r.cfg_pulse = 1'h0;
        r.stats_pulse = 1'h0;
        return r;
    endfunction

    logic wr_go;
    logic rd_go;
    assign wr_go = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    assign rd_go = s_axi_arvalid && !s_q.rvalid;

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        s_d = s_q;
        s_d.cfg_pulse = 1'b0;
        s_d.stats_pulse = 1'b0;
        s_d.used_valid = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_held = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        // Descriptors are taken one per cycle and used on the next.
        // The arrays of 4096-byte frame numbers stay in guest memory; only the queue index and descriptor id pass here.
        if (req_valid) begin
            if (mbal_queue_ok(req_queue, s_q.dev_feat)) begin
                s_d.used_valid = 1'b1;
                s_d.used_queue = req_queue;
                s_d.used_desc = req_desc_id;
                s_d.accepted = s_q.accepted + 32'h0000_0001;
            end
        end
        if (wr_go) begin
            s_d.aw_held = 1'b0;
            s_d.w_held = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = mbal_pkg::RESP_OKAY;
            if (s_q.aw_addr == mbal_pkg::OFF_DEV_FEATURES) begin
                s_d.dev_feat = s_q.w_data[2:0];
            end else if (s_q.aw_addr == mbal_pkg::OFF_DRV_FEATURES) begin
                s_d.drv_feat = s_q.w_data[2:0] & s_q.dev_feat;
            end else if (s_q.aw_addr == mbal_pkg::OFF_STATUS) begin
                s_d.status = s_q.w_data[7:0];
                // Only modern mode can report a refused negotiation.
                if (!s_q.legacy && s_q.dev_feat[mbal_pkg::FEAT_TELL_BEFORE_REUSE] &&
                    !s_q.drv_feat[mbal_pkg::FEAT_TELL_BEFORE_REUSE]) begin
                    s_d.status[mbal_pkg::STATUS_FEATURES_OK] = 1'b0;
                end
            end else if (s_q.aw_addr == mbal_pkg::OFF_CURRENT) begin
                // Bytes are staged; in legacy mode the count moves only with the top byte, otherwise with every write.
                s_d.current_stage = mbal_merge(s_q.current_stage, s_q.w_data, s_q.w_strb);
                if (!s_q.legacy || s_q.w_strb[3]) begin
                    s_d.current = mbal_merge(s_q.current_stage, s_q.w_data, s_q.w_strb);
                end
            end else if (s_q.aw_addr == mbal_pkg::OFF_HOST_TARGET) begin
                s_d.target = mbal_merge(s_q.target, s_q.w_data, s_q.w_strb);
                s_d.events[mbal_pkg::EVT_CONFIG_CHANGE] = 1'b1;
                s_d.cfg_pulse = 1'b1;
            end else if (s_q.aw_addr == mbal_pkg::OFF_EVENTS) begin
                s_d.events = s_q.events & ~s_q.w_data[1:0];
            end else if (s_q.aw_addr == mbal_pkg::OFF_QUEUE_SEL) begin
                s_d.queue_sel = s_q.w_data[1:0];
            end else if (s_q.aw_addr == mbal_pkg::OFF_QUEUE_NOTIFY) begin
                if (s_q.w_data[1:0] == mbal_pkg::QUEUE_STATS &&
                    s_q.drv_feat[mbal_pkg::FEAT_STATS_QUEUE_PRESENT] &&
                    s_q.status[mbal_pkg::STATUS_DRIVER_OK]) begin
                    s_d.events[mbal_pkg::EVT_STATS_READY] = 1'b1;
                    s_d.stats_pulse = 1'b1;
                end
            end else if (s_q.aw_addr == mbal_pkg::OFF_LEGACY) begin
                s_d.legacy = s_q.w_data[0];
            end else begin
                s_d.bresp = mbal_pkg::RESP_SLVERR;
            end
        end
        // The registered config-change set wins over a software clear in the same cycle.
        if (s_q.cfg_pulse) begin
            s_d.events[mbal_pkg::EVT_CONFIG_CHANGE] = 1'b1;
        end
        if (rd_go) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = mbal_pkg::RESP_OKAY;
            s_d.rdata = 32'h0000_0000;
            if (s_axi_araddr == mbal_pkg::OFF_DEV_FEATURES) begin
                s_d.rdata[2:0] = s_q.dev_feat;
            end else if (s_axi_araddr == mbal_pkg::OFF_DRV_FEATURES) begin
                s_d.rdata[2:0] = s_q.drv_feat;
            end else if (s_axi_araddr == mbal_pkg::OFF_STATUS) begin
                s_d.rdata[7:0] = s_q.status;
            end else if (s_axi_araddr == mbal_pkg::OFF_TARGET ||
                         s_axi_araddr == mbal_pkg::OFF_HOST_TARGET) begin
                s_d.rdata = s_q.target;
            end else if (s_axi_araddr == mbal_pkg::OFF_CURRENT) begin
                s_d.rdata = s_q.current;
            end else if (s_axi_araddr == mbal_pkg::OFF_EVENTS) begin
                s_d.rdata[1:0] = s_q.events;
            end else if (s_axi_araddr == mbal_pkg::OFF_QUEUE_SEL) begin
                s_d.rdata[1:0] = s_q.queue_sel;
            end else if (s_axi_araddr == mbal_pkg::OFF_QUEUE_AVAIL) begin
                s_d.rdata[0] = mbal_queue_ok(s_q.queue_sel, s_q.dev_feat);
            end else if (s_axi_araddr == mbal_pkg::OFF_ACCEPTED) begin
                s_d.rdata = s_q.accepted;
            end else if (s_axi_araddr == mbal_pkg::OFF_LEGACY) begin
                s_d.rdata[0] = s_q.legacy;
            end else if (s_axi_araddr == mbal_pkg::OFF_ID) begin
                s_d.rdata = DEVICE_ID;
            end else begin
                s_d.rresp = mbal_pkg::RESP_SLVERR;
            end
        end
    end

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= mbal_reset_state();
        end else begin
            s_q <= s_d;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    // Nothing new is taken while a response waits, so one write at most is under way.
    assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
    assign s_axi_wready = !s_q.w_held && !s_q.bvalid;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign req_ready = 1'b1;
    assign used_valid = s_q.used_valid;
    assign used_queue = s_q.used_queue;
    assign used_desc_id = s_q.used_desc;
    assign config_change = s_q.cfg_pulse;
    assign stats_request = s_q.stats_pulse;
    assign balloon_wants_more = s_q.target > s_q.current;
    assign balloon_wants_fewer = s_q.target < s_q.current;
    // Without negotiation, returned pages are the guest's at once.
    assign page_alter_allowed = s_q.drv_feat[mbal_pkg::FEAT_TELL_BEFORE_REUSE];
endmodule
`default_nettype wire

// ===== tb/mbal_device_chk.sv
// Checker for the memory balloon device: descriptor acknowledgement, bus answers and count flags.
// Assumes it is bound into the device and sees only the device's ports.
`timescale 1ns/1ps
`default_nettype none
module mbal_device_chk (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Descriptors and flags
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [1:0] req_queue,
    input wire logic [15:0] req_desc_id,
    input wire logic used_valid,
    input wire logic [1:0] used_queue,
    input wire logic [15:0] used_desc_id,
    input wire logic config_change,
    input wire logic balloon_wants_more,
    input wire logic balloon_wants_fewer
);
    // ****************
    // Properties
    // ****************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_used_follows_req: assert property (req_valid && req_queue < 2'h2 |=> used_valid &&
        used_queue == $past(req_queue) && used_desc_id == $past(req_desc_id)) else $error("used differs from request");
    a_used_needs_req: assert property (used_valid |-> $past(req_valid)) else $error("used without request");
    a_drop_bad_queue: assert property (req_valid && req_queue == 2'h3 |=> !used_valid) else $error("queue 3 used");
    a_req_always_ready: assert property (req_ready) else $error("descriptor port not ready");
    a_wants_exclusive: assert property (!(balloon_wants_more && balloon_wants_fewer)) else $error("more and fewer");
    a_cfg_single_pulse: assert property (config_change |=> !config_change) else $error("change pulse too long");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("address taken while busy");
    c_used: cover property (used_valid);
    c_change: cover property (config_change);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == mbal_pkg::RESP_SLVERR);
    c_more: cover property (balloon_wants_more);
endmodule
bind mbal_device mbal_device_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .req_valid, .req_ready,
    .req_queue, .req_desc_id, .used_valid, .used_queue, .used_desc_id, .config_change, .balloon_wants_more,
    .balloon_wants_fewer);
`default_nettype wire

// ===== tb/mbal_queue_model.sv
// Queue engine model: hands the device one descriptor per posted request.
// Assumes the bench posts at most one request a cycle.
`timescale 1ns/1ps
`default_nettype none
module mbal_queue_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Requests from the bench
    input wire logic post,
    input wire logic [1:0] post_queue,
    input wire logic [15:0] post_id,
    // Descriptor port
    output logic req_valid = 1'h0,
    output logic [1:0] req_queue = 2'h0,
    output logic [15:0] req_desc_id = 16'h0
);
    // Idle lines flip every cycle so a stale value can never look like a request field.
    always @(posedge aclk) begin
        req_valid <= aresetn && post;
        if (aresetn && post) begin
            req_queue <= post_queue;
            req_desc_id <= post_id;
        end else begin
            req_queue <= ~req_queue;
            req_desc_id <= ~req_desc_id;
        end
    end
endmodule
`default_nettype wire

// ===== tb/mbal_device_tb_top.sv
// Bench for the memory balloon device: registers, negotiation, counts and descriptor acknowledgement.
// Assumes the checker is bound into the device and the queue model feeds its descriptor port.
`timescale 1ns/1ps
`default_nettype none
module mbal_device_tb_top;
    // ****************
    // Signals
    // ****************
    logic aclk = 1'h0, aresetn = 1'h0, post = 1'h0, stats_on = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got, t, c;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, req_valid, req_ready, used_valid;
    logic config_change, stats_request, balloon_wants_more, balloon_wants_fewer, page_alter_allowed;
    logic [1:0] s_axi_bresp, s_axi_rresp, req_queue, used_queue, last_resp, post_queue = 2'h0;
    logic [15:0] req_desc_id, used_desc_id, post_id = 16'h0;
    logic [17:0] exp_q[$];
    int mismatches = 0, comparisons = 0, cc_cnt = 0, cc0, i, sr_cnt = 0, sr0, acc_n = 0;
    always #5 aclk = ~aclk;
    mbal_device DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid, .req_ready, .req_queue,
        .req_desc_id, .used_valid, .used_queue, .used_desc_id, .config_change, .stats_request, .balloon_wants_more,
        .balloon_wants_fewer, .page_alter_allowed);
    mbal_queue_model u_drv (.aclk, .aresetn, .post, .post_queue, .post_id, .req_valid, .req_queue, .req_desc_id);
    // ****************
    // Tasks and monitors
    // ****************
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 40 && !(s_axi_bvalid && n > 0); n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        last_resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        if (n == 40) begin
            mismatches++;
            end_of_test();
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 40 && !(s_axi_rvalid && n > 0); n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        d = s_axi_rdata;
        last_resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        if (n == 40) begin
            mismatches++;
            end_of_test();
        end
    endtask
    always @(posedge aclk) begin
        if (config_change) cc_cnt <= cc_cnt + 1;
        if (stats_request) sr_cnt <= sr_cnt + 1;
        if (aresetn && used_valid) begin
            chk("used", {14'h0, exp_q.size() > 0 ? exp_q.pop_front() : 18'h3ffff}, {14'h0, used_queue, used_desc_id});
        end
        if (aresetn && req_valid && (req_queue < 2'h2 || (req_queue == 2'h2 && stats_on))) begin
            exp_q.push_back({req_queue, req_desc_id});
            acc_n <= acc_n + 1;
        end
    end
    // ****************
    // Sequence
    // ****************
    initial begin
        void'($urandom(96));
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 5; i++) begin
            rd(8'(i * 4), got);
            chk("reset value", (i == 0) ? 32'h7 : 32'h0, got);
        end
        rd(8'h3c, got);
        chk("unmapped read", {30'h0, mbal_pkg::RESP_SLVERR}, {30'h0, last_resp});
        wr(mbal_pkg::OFF_DRV_FEATURES, 32'h6, 4'hf);
        wr(mbal_pkg::OFF_STATUS, 32'h8, 4'hf);
        rd(mbal_pkg::OFF_STATUS, got);
        chk("refused ok", 32'h0, {31'h0, got[3]});
        chk("alter off", 32'h0, {31'h0, page_alter_allowed});
        wr(mbal_pkg::OFF_DRV_FEATURES, 32'h7, 4'hf);
        wr(mbal_pkg::OFF_STATUS, 32'hc, 4'hf);
        rd(mbal_pkg::OFF_STATUS, got);
        chk("accepted ok", 32'h3, {30'h0, got[3:2]});
        chk("alter on", 32'h1, {31'h0, page_alter_allowed});
        wr(mbal_pkg::OFF_TARGET, 32'h1234, 4'hf);
        chk("read-only write", {30'h0, mbal_pkg::RESP_SLVERR}, {30'h0, last_resp});
        rd(mbal_pkg::OFF_TARGET, got);
        chk("target kept", 32'h0, got);
        rd(mbal_pkg::OFF_ID, got);
        chk("identity", mbal_pkg::DEVICE_ID_DEFAULT, got);
        wr(mbal_pkg::OFF_QUEUE_SEL, 32'h2, 4'hf);
        rd(mbal_pkg::OFF_QUEUE_AVAIL, got);
        chk("stats queue offered", 32'h1, got);
        sr0 = sr_cnt;
        wr(mbal_pkg::OFF_QUEUE_NOTIFY, 32'h2, 4'hf);
        chk("notify resp", {30'h0, mbal_pkg::RESP_OKAY}, {30'h0, last_resp});
        repeat (2) @(posedge aclk);
        chk("stats request", 32'(sr0 + 1), 32'(sr_cnt));
        rd(mbal_pkg::OFF_EVENTS, got);
        chk("stats event", 32'h2, got);
        wr(mbal_pkg::OFF_EVENTS, 32'h2, 4'hf);
        rd(mbal_pkg::OFF_EVENTS, got);
        chk("event cleared", 32'h0, got);
        for (i = 0; i < 13; i++) begin
            @(posedge aclk);
            post <= (i % 5) != 4;
            post_queue <= 2'(i % 4);
            post_id <= 16'($urandom);
        end
        wr(mbal_pkg::OFF_DEV_FEATURES, 32'h5, 4'hf);
        stats_on = 1'h0;
        post <= 1'h0;
        wr(mbal_pkg::OFF_DRV_FEATURES, 32'h7, 4'hf);
        rd(mbal_pkg::OFF_DRV_FEATURES, got);
        chk("masked", 32'h5, got);
        rd(mbal_pkg::OFF_QUEUE_AVAIL, got);
        chk("stats queue withdrawn", 32'h0, got);
        @(posedge aclk);
        post <= 1'h1;
        post_queue <= mbal_pkg::QUEUE_STATS;
        @(posedge aclk);
        post <= 1'h0;
        for (i = 0; i < 8; i++) begin
            t = (i == 0) ? 32'hffff_ffff : $urandom;
            c = (i == 1) ? t : $urandom;
            cc0 = cc_cnt;
            wr(mbal_pkg::OFF_HOST_TARGET, t, 4'hf);
            repeat (4) @(posedge aclk);
            chk("change count", 32'(cc0 + 1), 32'(cc_cnt));
            wr(mbal_pkg::OFF_CURRENT, c, 4'hf);
            rd(mbal_pkg::OFF_TARGET, got);
            chk("target", t, got);
            chk("wants", {30'h0, t > c, t < c}, {30'h0, balloon_wants_more, balloon_wants_fewer});
        end
        wr(mbal_pkg::OFF_CURRENT, 32'hab, 4'h1);
        rd(mbal_pkg::OFF_CURRENT, got);
        chk("low byte lane", {c[31:8], 8'hab}, got);
        wr(mbal_pkg::OFF_LEGACY, 32'h1, 4'hf);
        wr(mbal_pkg::OFF_CURRENT, 32'h1122_3344, 4'hf);
        wr(mbal_pkg::OFF_CURRENT, 32'haa, 4'h1);
        rd(mbal_pkg::OFF_CURRENT, got);
        chk("staged", 32'h1122_3344, got);
        wr(mbal_pkg::OFF_CURRENT, 32'h5500_0000, 4'h8);
        rd(mbal_pkg::OFF_CURRENT, got);
        chk("applied", 32'h55aa, {16'h0, got[31:24], got[7:0]});
        wr(mbal_pkg::OFF_DRV_FEATURES, 32'h0, 4'hf);
        wr(mbal_pkg::OFF_STATUS, 32'h8, 4'hf);
        rd(mbal_pkg::OFF_STATUS, got);
        chk("legacy ok", 32'h1, {31'h0, got[3]});
        rd(mbal_pkg::OFF_ACCEPTED, got);
        chk("accepted count", 32'(acc_n), got);
        chk("pending", 32'h0, 32'(exp_q.size()));
        end_of_test();
    end
endmodule
`default_nettype wire
